// >>> design/vacant_access_flag_logic.sv
/*
 vacant access flag logic: flags accesses to unpopulated memory, sequences multi-register
 pops with their trailing extra read, and flags pc-modifying fetches at a region's top.
 assumes the cpu presents one access per cycle and the memory map reports populated addresses.
*/
// Overview of operation
// - multi pop issues extra read after last increment
// - extra read on vacant address sets flag
// - flag requests interrupt only while enabled
// - extra read vacant only at or above stack top
// - pc-modifying fetch at region top may flag
// - debug with breakpoints: last 8 bytes affected
// - free running: last 4 bytes affected
`timescale 1ns/1ps
module vacant_access_flag_logic
    import vacant_access_pkg::*;
#(
    parameter logic [19:0] region_top = vacant_access_pkg::region_top_default,
    parameter logic [19:0] stack_top = vacant_access_pkg::stack_top_default
) (
    input wire logic mclk,
    input wire logic rst,
    input wire vacant_access_pkg::cpu_access_s cpu_access,
    input wire vacant_access_pkg::pop_cmd_s pop_cmd,
    input wire logic addr_populated,
    input wire logic debug_breakpoints,
    input wire logic vacant_access_int_enable,
    input wire logic flag_clear,
    output logic vacant_access_flag,
    output logic vacant_irq,
    output logic pop_busy,
    output logic pop_read_valid,
    output logic [19:0] pop_read_addr,
    output logic extra_read_valid
);
    import vacant_access_pkg::*;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_pop = 2'b01,
        st_extra = 2'b10
    } pop_state_e;

    pop_state_e state, next_state;
    logic [3:0] remaining, next_remaining;
    logic [19:0] sp, next_sp;
    logic step_addr, next_step_addr;
    logic [19:0] step_size;
    logic next_pop_read_valid, next_extra_read_valid;
    logic [19:0] next_pop_read_addr;
    logic next_pop_busy;
    logic next_flag, next_irq;
    logic [19:0] window;
    logic [19:0] window_base;
    logic fetch_pc_modify;
    logic fetch_in_window;
    logic fetch_hazard;
    logic access_vacant;
    logic pop_vacant;
    logic set_event;

    // word pops move sp by 2, address-word pops by 4
    assign step_size = step_addr ? addr_word_step : word_step;

    // pop sequencer: one read per register, then the stray read at the final sp
    always_comb begin
        next_state = state;
        next_remaining = remaining;
        next_sp = sp;
        next_step_addr = step_addr;
        next_pop_read_valid = 1'b0;
        next_extra_read_valid = 1'b0;
        next_pop_read_addr = pop_read_addr;
        case (state)
            st_idle: begin
                // a start while busy never reaches here, so it is simply lost
                if (pop_cmd.start && pop_cmd.count != 4'h0) begin
                    next_state = st_pop;
                    next_remaining = pop_cmd.count;
                    next_sp = pop_cmd.sp;
                    next_step_addr = pop_cmd.addr_form;
                end else begin
                    next_state = st_idle;
                    next_remaining = remaining;
                    next_sp = sp;
                    next_step_addr = step_addr;
                end
            end
            st_pop: begin
                next_pop_read_valid = 1'b1;
                next_extra_read_valid = 1'b0;
                next_pop_read_addr = sp;
                next_sp = sp + step_size;
                next_remaining = remaining - 4'h1;
                if (remaining == 4'h1) begin
                    next_state = st_extra;
                end else begin
                    next_state = st_pop;
                end
            end
            st_extra: begin
                // the stray read hits sp after its last increment
                next_pop_read_valid = 1'b0;
                next_extra_read_valid = 1'b1;
                next_pop_read_addr = sp;
                next_sp = sp;
                next_remaining = 4'h0;
                next_state = st_idle;
            end
            default: begin
                next_pop_read_valid = 1'b0;
                next_extra_read_valid = 1'b0;
                next_remaining = 4'h0;
                next_sp = sp;
                next_step_addr = step_addr;
                next_state = st_idle;
            end
        endcase
        next_pop_busy = next_state != st_idle;
    end

    // registers only; every next value settles in the block above
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= st_idle;
            remaining <= 4'h0;
            sp <= 20'h00000;
            step_addr <= 1'b0;
            pop_read_valid <= 1'b0;
            extra_read_valid <= 1'b0;
            pop_read_addr <= 20'h00000;
            pop_busy <= 1'b0;
        end else begin
            state <= next_state;
            remaining <= next_remaining;
            sp <= next_sp;
            step_addr <= next_step_addr;
            pop_read_valid <= next_pop_read_valid;
            extra_read_valid <= next_extra_read_valid;
            pop_read_addr <= next_pop_read_addr;
            pop_busy <= next_pop_busy;
        end
    end

    // fetch window: debug stalls lengthen prefetch, so the exposed tail doubles
    always_comb begin
        window = free_window_bytes;
        case (debug_breakpoints)
            1'b1: begin
                window = debug_window_bytes;
            end
            1'b0: begin
                window = free_window_bytes;
            end
            default: begin
                window = free_window_bytes;
            end
        endcase
    end

    // region_top must lie at or above the window size or the base wraps
    assign window_base = region_top - window;
    assign fetch_pc_modify = cpu_access.kind == acc_fetch && cpu_access.pc_modify;
    assign fetch_in_window = cpu_access.addr <= region_top && cpu_access.addr > window_base;
    assign fetch_hazard = fetch_pc_modify && fetch_in_window;
    assign access_vacant = cpu_access.kind != acc_none && !addr_populated;
    // only a pop reaching the stack top reads past populated memory
    assign pop_vacant = extra_read_valid && pop_read_addr >= stack_top;
    assign set_event = access_vacant || pop_vacant || fetch_hazard;

    // flag: sticky, a new event wins over a same-cycle clear
    always_comb begin
        next_flag = vacant_access_flag;
        case ({set_event, flag_clear})
            2'b00: begin
                next_flag = vacant_access_flag;
            end
            2'b01: begin
                next_flag = 1'b0;
            end
            2'b10: begin
                next_flag = 1'b1;
            end
            2'b11: begin
                // clearing here would lose the event for good
                next_flag = 1'b1;
            end
            default: begin
                next_flag = vacant_access_flag;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            vacant_access_flag <= 1'b0;
        end else begin
            vacant_access_flag <= next_flag;
        end
    end

    // irq follows the flag value being stored, so both rise on one edge
    always_comb begin
        next_irq = 1'b0;
        if (vacant_access_int_enable) begin
            next_irq = next_flag;
        end
    end

    // enable is sampled, so dropping it masks the request one cycle later
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            vacant_irq <= 1'b0;
        end else begin
            vacant_irq <= next_irq;
        end
    end
endmodule

// >>> design/vacant_access_pkg.sv
/*
 vacant access flag package: access carrier struct, kinds, region limits and window sizes.
 assumes a 20-bit byte address space on one system clock.
*/
package vacant_access_pkg;
    localparam int addr_w = 20;
    localparam logic [19:0] stack_top_default = 20'h04400;
    localparam logic [19:0] region_top_default = 20'h0ffff;
    localparam logic [19:0] debug_window_bytes = 20'h00008;
    localparam logic [19:0] free_window_bytes = 20'h00004;
    localparam logic [19:0] addr_word_step = 20'h00004;
    localparam logic [19:0] word_step = 20'h00002;

    typedef enum logic [1:0] {
        acc_none = 2'b00,
        acc_fetch = 2'b01,
        acc_read = 2'b10,
        acc_write = 2'b11
    } acc_kind_e;

    typedef struct packed {
        acc_kind_e kind;
        logic [19:0] addr;
        logic pc_modify;
    } cpu_access_s;

    typedef struct packed {
        logic start;
        logic addr_form;
        logic [3:0] count;
        logic [19:0] sp;
    } pop_cmd_s;
endpackage

// >>> verif/mem_map_model.sv
/* memory map partner: says if an address is populated
 assumes the bench feeds it the cpu access address */
`timescale 1ns/1ps
module mem_map_model (
    input wire logic [19:0] addr,
    output logic populated
);
    // ram below stack top, code up to region top, vacant gap between
    assign populated = addr < 20'h04400 || addr >= 20'h08000 && addr <= 20'h0ffff;
endmodule

// >>> verif/tb_vacant_access_flag_logic.sv
/* testbench for the vacant access flag logic
 assumes default stack and region tops */
`timescale 1ns/1ps
module tb_vacant_access_flag_logic;
    import vacant_access_pkg::*;
    logic mclk = 0, rst = 1, addr_populated, debug_breakpoints = 0, vacant_access_int_enable = 0, flag_clear = 0;
    cpu_access_s cpu_access = '0;
    pop_cmd_s pop_cmd = '0;
    logic vacant_access_flag, vacant_irq, pop_busy, pop_read_valid, extra_read_valid;
    logic [19:0] pop_read_addr;
    int errors = 0, checked = 0, cyc = 0;
    vacant_access_flag_logic vacant_access_flag_logic_inst (.*);
    mem_map_model mem_map_model_inst (.addr(cpu_access.addr), .populated(addr_populated));
    initial forever #50 mclk = ~mclk;
    task chk(input string what, input logic [19:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task clear_flag;
        @(posedge mclk) flag_clear <= 1;
        @(posedge mclk) flag_clear <= 0;
        @(posedge mclk);
    endtask
    task pop_case(input logic form, input logic [3:0] n, input logic [19:0] sp, input logic flag);
        int pops, ex, busy;
        pops = 0;
        ex = 0;
        busy = 0;
        clear_flag;
        pop_cmd <= '{1'b1, form, n, sp};
        @(posedge mclk) pop_cmd.start <= 0;
        #1 chk("busy on", pop_busy, 1);
        repeat (20) begin
            @(posedge mclk) #1;
            ex += extra_read_valid;
            busy += pop_busy;
            if (pop_read_valid) chk("pop addr", pop_read_addr, sp + pops++ * (form ? 4 : 2));
            if (extra_read_valid) chk("extra addr", pop_read_addr, sp + n * (form ? 4 : 2));
        end
        chk("pops", pops, n);
        chk("extra", ex, 1);
        chk("busy cycles", busy, n);
        chk("busy off", pop_busy, 0);
        chk("pop flag", vacant_access_flag, flag);
    endtask
    task fetch_case(input logic dbg, input logic [19:0] off, input logic flag);
        clear_flag;
        debug_breakpoints <= dbg;
        cpu_access <= '{acc_fetch, region_top_default - off, 1'b1};
        @(posedge mclk) cpu_access <= '0;
        @(posedge mclk) #1 chk("fetch flag", vacant_access_flag, flag);
    endtask
    task vacant_case(input acc_kind_e kind);
        clear_flag;
        cpu_access <= '{kind, 20'h05000, 1'b0};
        flag_clear <= 1;
        @(posedge mclk) cpu_access <= '0;
        flag_clear <= 0;
        @(posedge mclk) #1 chk("vacant set", vacant_access_flag, 1);
        @(posedge mclk) flag_clear <= 1;
        @(posedge mclk) flag_clear <= 0;
        @(posedge mclk) #1 chk("cleared", vacant_access_flag, 0);
    endtask
    task irq_case;
        @(posedge mclk) vacant_access_int_enable <= 1;
        repeat (2) @(posedge mclk);
        #1 chk("irq on", vacant_irq, 1);
        vacant_access_int_enable <= 0;
        repeat (2) @(posedge mclk);
        #1 chk("irq off", vacant_irq, 0);
        chk("flag kept", vacant_access_flag, 1);
    endtask
    task report_and_stop;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            errors++;
            report_and_stop;
        end
    end
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 0;
        @(posedge mclk);
        pop_case(1, 2, 20'h043f4, 0);
        pop_case(1, 2, 20'h043f8, 1);
        pop_case(0, 3, 20'h043f8, 0);
        pop_case(0, 4, 20'h043f8, 1);
        vacant_case(acc_read);
        vacant_case(acc_write);
        fetch_case(1, 7, 1);
        fetch_case(0, 7, 0);
        fetch_case(0, 4, 0);
        fetch_case(0, 3, 1);
        irq_case;
        report_and_stop;
    end
endmodule
bind vacant_access_flag_logic vacant_access_flag_sva #(.region_top(region_top), .stack_top(stack_top)) sva_inst (.*);

// >>> verif/vacant_access_flag_sva.sv
/* checker for the vacant access flag logic
 bound to its top module, sees its ports only */
`timescale 1ns/1ps
module vacant_access_flag_sva
    import vacant_access_pkg::*;
#(
    parameter logic [19:0] region_top = 20'h0ffff,
    parameter logic [19:0] stack_top = 20'h04400
) (
    input wire logic mclk,
    input wire logic rst,
    input wire vacant_access_pkg::cpu_access_s cpu_access,
    input wire logic flag_clear,
    input wire logic debug_breakpoints,
    input wire logic vacant_access_int_enable,
    input wire logic vacant_access_flag,
    input wire logic vacant_irq,
    input wire logic pop_read_valid,
    input wire logic [19:0] pop_read_addr,
    input wire logic extra_read_valid
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire hz = cpu_access.kind == acc_fetch && cpu_access.pc_modify && cpu_access.addr <= region_top;
    irq_gate_a: assert property (vacant_irq == (vacant_access_flag && $past(vacant_access_int_enable)))
        else $error("irq differs from flag and enable");
    irq_off_a: assert property (!vacant_access_int_enable |=> !vacant_irq) else $error("irq while disabled");
    extra_follow_a: assert property ($fell(pop_read_valid) |-> extra_read_valid) else $error("no extra read");
    extra_flag_a: assert property (extra_read_valid && pop_read_addr >= stack_top |=> vacant_access_flag)
        else $error("extra read at top not flagged");
    no_spurious_a: assert property (extra_read_valid && pop_read_addr < stack_top && cpu_access.kind == acc_none
        && !vacant_access_flag |=> !vacant_access_flag) else $error("extra read below top flagged");
    flag_sticky_a: assert property (vacant_access_flag && !flag_clear |=> vacant_access_flag)
        else $error("flag dropped");
    fetch_dbg_a: assert property (hz && debug_breakpoints && cpu_access.addr > region_top - debug_window_bytes
        |=> vacant_access_flag) else $error("debug window fetch not flagged");
    fetch_free_a: assert property (hz && cpu_access.addr > region_top - free_window_bytes
        |=> vacant_access_flag) else $error("free window fetch not flagged");
endmodule
